// ==== hdl/mic_top.sv ====
// mac interface control register, rmii receive elasticity buffer and interrupt
// assumes an apb master on clk, straps and recovered receive link on pins
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "mic_regs.svh"
module mic_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic strap_rx_dly,
    input wire logic strap_tx_dly,
    input wire logic strap_rgmii,
    input wire logic strap_clk_sel,
    input wire logic strap_rmii,
    input wire logic link_clk,
    input wire logic link_dv,
    input wire logic [1:0] link_data,
    output logic crs_dv,
    output logic [1:0] rxd,
    output logic [1:0] if_mode,
    output logic ref_50m,
    output logic rx_clk_dly_en,
    output logic tx_clk_dly_en,
    output logic [3:0] sgmii_thr_bits,
    output logic [2:0] eb_tol_bits,
    output logic irq
);

    // sgmii half-full level in bits
    function automatic logic [3:0] sgmii_bits(input logic [1:0] code);
        case (code)
            2'h0: sgmii_bits = 4'h5;
            2'h1: sgmii_bits = 4'h2;
            2'h2: sgmii_bits = 4'h6;
            default: sgmii_bits = 4'ha;
        endcase
    endfunction
    // elasticity tolerance in bits
    function automatic logic [2:0] tol_bits(input logic [1:0] code);
        case (code)
            2'h0: tol_bits = 3'h5;
            2'h1: tol_bits = 3'h2;
            2'h2: tol_bits = 3'h3;
            default: tol_bits = 3'h4;
        endcase
    endfunction
    localparam logic [3:0] DRAIN_CYC = 4'(`MIC_DRAIN_CYC - 1);
    localparam logic [4:0] EB_FULL = 5'(`MIC_EB_DEPTH);

    mic_pkg::mic_ctrl_t ctrl_ff;
    mic_pkg::mic_strap_t strap_raw;
    mic_pkg::mic_strap_t strap_s;
    mic_pkg::mic_dibit_t link_s;
    mic_pkg::mic_eb_state_t eb_state_ff;
    logic link_clk_s;
    logic link_clk_prev_ff;
    logic link_rise;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wr_en;
    logic rd_en;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic ovf_ev_ff;
    logic unf_ev_ff;
    logic ovf_set;
    logic unf_set;
    logic [1:0] int_stat_ff;
    logic [1:0] int_mask_ff;
    logic irq_ff;
    logic [1:0] eb_mem [`MIC_EB_DEPTH];
    logic [3:0] wr_ptr_ff;
    logic [3:0] rd_ptr_ff;
    logic [4:0] cnt_ff;
    logic push;
    logic pop;
    logic [3:0] tick_cnt_ff;
    logic tick;
    logic carrier_ff;
    logic crs_dv_ff;
    logic [1:0] rxd_ff;
    logic toggle_ff;
    logic [1:0] mode_ff;
    logic ref_50m_ff;
    logic rx_dly_ff;
    logic tx_dly_ff;
    logic [3:0] sgmii_ff;
    logic [2:0] tol_ff;
    logic [15:0] ctrl_rd;

    assign strap_raw = '{rx_dly: strap_rx_dly, tx_dly: strap_tx_dly, rgmii: strap_rgmii,
                         clk_sel: strap_clk_sel, rmii: strap_rmii};
    mic_sync #(.WIDTH(5)) u_strap_sync (
        .clk(clk),
        .rst(1'b0),
        .async_in(strap_raw),
        .sync_out(strap_s)
    );
    mic_sync #(.WIDTH(4)) u_link_sync (
        .clk(clk),
        .rst(rst),
        .async_in({link_clk, link_dv, link_data}),
        .sync_out({link_clk_s, link_s})
    );
    // apb decode
    assign hit_ctrl = (paddr == `MIC_CTRL_ADDR);
    assign hit_stat = (paddr == `MIC_INT_STAT_ADDR);
    assign hit_mask = (paddr == `MIC_INT_MASK_ADDR);
    assign wr_en = psel & penable & pready_ff & pwrite;
    assign rd_en = psel & penable & pready_ff & ~pwrite;

    // status bits read 0 while an event is pending
    assign ctrl_rd = {1'b0, ctrl_ff[12:2], ~ovf_ev_ff, ~unf_ev_ff, ctrl_ff[1:0]};

    // one wait-free access: ready rises in the first access cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (psel & ~penable & ~pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~(hit_ctrl | hit_stat | hit_mask);
            if (hit_ctrl) begin
                prdata_ff <= {16'h0, ctrl_rd};
            end else if (hit_stat) begin
                prdata_ff <= {30'h0, int_stat_ff};
            end else if (hit_mask) begin
                prdata_ff <= {30'h0, int_mask_ff};
            end else begin
                prdata_ff <= 32'h0;
            end
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // control register; straps load while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff.sgmii_thr <= `MIC_RST_SGMII_THR;
            ctrl_ff.rx_dly <= strap_s.rx_dly;
            ctrl_ff.tx_dly <= strap_s.tx_dly;
            ctrl_ff.rsv10 <= 1'b0;
            ctrl_ff.rgmii <= strap_s.rgmii;
            ctrl_ff.rsv8 <= 1'b0;
            ctrl_ff.clk_sel <= strap_s.clk_sel;
            ctrl_ff.rsv6 <= `MIC_RST_RSV6;
            ctrl_ff.rmii <= strap_s.rmii;
            ctrl_ff.rmii_rev <= `MIC_RST_RMII_REV;
            ctrl_ff.eb_size <= `MIC_RST_EB_SIZE;
        end else if (wr_en & hit_ctrl) begin
            ctrl_ff <= {pwdata[`MIC_F_SGMII_THR], pwdata[`MIC_F_RX_DLY:`MIC_F_RMII_REV], pwdata[`MIC_F_EB_SIZE]};
        end
    end

    // decoded settings held in flops for the outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff <= mic_pkg::MIC_MODE_MII;
            ref_50m_ff <= 1'b0;
            rx_dly_ff <= 1'b0;
            tx_dly_ff <= 1'b0;
            sgmii_ff <= 4'h0;
            tol_ff <= 3'h0;
        end else begin
            if (ctrl_ff.rgmii) begin
                mode_ff <= mic_pkg::MIC_MODE_RGMII;
            end else if (ctrl_ff.rmii) begin
                mode_ff <= mic_pkg::MIC_MODE_RMII;
            end else begin
                mode_ff <= mic_pkg::MIC_MODE_MII;
            end
            ref_50m_ff <= ctrl_ff.clk_sel;
            rx_dly_ff <= ctrl_ff.rx_dly & ctrl_ff.rgmii;
            tx_dly_ff <= ctrl_ff.tx_dly & ctrl_ff.rgmii;
            sgmii_ff <= sgmii_bits(ctrl_ff.sgmii_thr);
            tol_ff <= tol_bits(ctrl_ff.eb_size);
        end
    end

    // link clock rising edges found from the synchronised level
    always_ff @(posedge clk) begin
        if (rst) begin
            link_clk_prev_ff <= 1'b0;
        end else begin
            link_clk_prev_ff <= link_clk_s;
        end
    end
    assign link_rise = link_clk_s & ~link_clk_prev_ff;
    assign push = link_rise & link_s.dv & (mode_ff == mic_pkg::MIC_MODE_RMII) & (cnt_ff != EB_FULL);
    assign ovf_set = link_rise & link_s.dv & (mode_ff == mic_pkg::MIC_MODE_RMII) & (cnt_ff == EB_FULL);
    assign pop = tick & (eb_state_ff == mic_pkg::MIC_EB_DRAIN) & (cnt_ff != 5'h0);
    assign unf_set = tick & (eb_state_ff == mic_pkg::MIC_EB_DRAIN) & (cnt_ff == 5'h0) & carrier_ff;
    always_ff @(posedge clk) begin
        if (push) begin
            eb_mem[wr_ptr_ff] <= link_s.data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= 4'h0;
            rd_ptr_ff <= 4'h0;
            cnt_ff <= 5'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 4'h1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 4'h1;
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + 5'h1;
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - 5'h1;
            end
        end
    end

    // rmii dibit pacing
    always_ff @(posedge clk) begin
        if (rst | tick) begin
            tick_cnt_ff <= 4'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
        end
    end
    assign tick = (tick_cnt_ff == DRAIN_CYC);
    always_ff @(posedge clk) begin
        if (rst) begin
            carrier_ff <= 1'b0;
        end else begin
            carrier_ff <= link_s.dv & (mode_ff == mic_pkg::MIC_MODE_RMII);
        end
    end
    // drain starts once the tolerance is buffered or carrier drops
    always_ff @(posedge clk) begin
        if (rst) begin
            eb_state_ff <= mic_pkg::MIC_EB_IDLE;
        end else begin
            case (eb_state_ff)
                mic_pkg::MIC_EB_IDLE: begin
                    if (push) begin
                        eb_state_ff <= mic_pkg::MIC_EB_FILL;
                    end
                end
                mic_pkg::MIC_EB_FILL: begin
                    if ({cnt_ff, 1'b0} >= {3'h0, tol_ff} || !carrier_ff) begin
                        eb_state_ff <= mic_pkg::MIC_EB_DRAIN;
                    end
                end
                mic_pkg::MIC_EB_DRAIN: begin
                    if (tick && cnt_ff == 5'h0 && !carrier_ff) begin
                        eb_state_ff <= mic_pkg::MIC_EB_IDLE;
                    end
                end
                default: eb_state_ff <= mic_pkg::MIC_EB_IDLE;
            endcase
        end
    end

    // receive outputs toward the mac
    always_ff @(posedge clk) begin
        if (rst) begin
            crs_dv_ff <= 1'b0;
            rxd_ff <= 2'h0;
            toggle_ff <= 1'b0;
        end else if (eb_state_ff == mic_pkg::MIC_EB_IDLE) begin
            crs_dv_ff <= 1'b0;
            rxd_ff <= 2'h0;
            toggle_ff <= 1'b0;
        end else if (tick) begin
            if (pop) begin
                rxd_ff <= eb_mem[rd_ptr_ff];
            end else begin
                rxd_ff <= 2'h0;
            end
            if (eb_state_ff == mic_pkg::MIC_EB_DRAIN && cnt_ff == 5'h0 && !carrier_ff) begin
                crs_dv_ff <= 1'b0;
            end else if (!carrier_ff && !ctrl_ff.rmii_rev && eb_state_ff == mic_pkg::MIC_EB_DRAIN) begin
                toggle_ff <= ~toggle_ff;
                crs_dv_ff <= toggle_ff;
            end else begin
                crs_dv_ff <= 1'b1;
            end
        end
    end

    // pending events, cleared by a control register read, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_ev_ff <= 1'b1;
            unf_ev_ff <= 1'b1;
        end else begin
            ovf_ev_ff <= ovf_set | (ovf_ev_ff & ~(rd_en & hit_ctrl));
            unf_ev_ff <= unf_set | (unf_ev_ff & ~(rd_en & hit_ctrl));
        end
    end

    // interrupt status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            int_stat_ff <= 2'h0;
        end else begin
            int_stat_ff[`MIC_INT_OVF] <= ovf_set |
                (int_stat_ff[`MIC_INT_OVF] & ~(wr_en & hit_stat & pwdata[`MIC_INT_OVF]));
            int_stat_ff[`MIC_INT_UNF] <= unf_set |
                (int_stat_ff[`MIC_INT_UNF] & ~(wr_en & hit_stat & pwdata[`MIC_INT_UNF]));
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            int_mask_ff <= `MIC_RST_INT_MASK;
        end else if (wr_en & hit_mask) begin
            int_mask_ff <= pwdata[1:0];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign crs_dv = crs_dv_ff;
    assign rxd = rxd_ff;
    assign if_mode = mode_ff;
    assign ref_50m = ref_50m_ff;
    assign rx_clk_dly_en = rx_dly_ff;
    assign tx_clk_dly_en = tx_dly_ff;
    assign sgmii_thr_bits = sgmii_ff;
    assign eb_tol_bits = tol_ff;
    assign irq = irq_ff;

endmodule

// ==== pkg/mic_regs.svh ====
// offsets, field positions, reset values and timing counts of the mac interface control block
// assumes a 32-bit apb slave on a 40 MHz clock
// Function
// - sgmii threshold code selects 5, 2, 6 or 10 bit half-full; resets to 10
// - rgmii receive delay bit delays receive clock 2 ns; resets from strap
// - rgmii transmit delay bit delays transmit clock 2 ns; resets from strap
// - rgmii select bit 1 picks rgmii, else rmii select bit decides
// - without rgmii, rmii select 1 gives rmii, 0 gives mii; strap reset
// - clock select strap: 1 means 50 MHz oscillator, 0 means 25 MHz
// - rmii revision 1.0 keeps crs_dv high until last data leaves
// - rmii revision 1.2 toggles crs_dv after carrier drops while data drains
// - overflow status reads 0 on receive buffer overflow, clears on read
// - underflow status reads 0 on receive buffer underflow, clears on read
// - elasticity field sets tolerance 5, 2, 3 or 4 bits; resets to 01
// - elasticity buffer absorbs link and rmii clock rate differences
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

`define MIC_CTRL_IDX 8'h17
`define MIC_CTRL_ADDR 12'h05c
`define MIC_INT_STAT_ADDR 12'h100
`define MIC_INT_MASK_ADDR 12'h104

`define MIC_F_SGMII_THR 14:13
`define MIC_F_RX_DLY 12
`define MIC_F_TX_DLY 11
`define MIC_F_RGMII 9
`define MIC_F_CLK_SEL 7
`define MIC_F_RMII 5
`define MIC_F_RMII_REV 4
`define MIC_F_OVF 3
`define MIC_F_UNF 2
`define MIC_F_EB_SIZE 1:0
`define MIC_CTRL_WMASK 16'h7ff3

`define MIC_RST_SGMII_THR 2'h2
`define MIC_RST_RSV6 1'h1
`define MIC_RST_RMII_REV 1'h0
`define MIC_RST_EB_SIZE 2'h1
`define MIC_RST_INT_MASK 2'h0

`define MIC_INT_OVF 0
`define MIC_INT_UNF 1

`define MIC_CLK_PERIOD_NS 25
`define MIC_LINK_PERIOD_NS 200
`define MIC_DRAIN_CYC (`MIC_LINK_PERIOD_NS / `MIC_CLK_PERIOD_NS)
`define MIC_CLK_DLY_PS 2000
`define MIC_EB_DEPTH 16

`endif

// ==== pkg/mic_pkg.sv ====
// types of the mac interface control block
// assumes mic_regs.svh for the numbers
package mic_pkg;

    typedef enum logic [1:0] {
        MIC_MODE_MII,
        MIC_MODE_RMII,
        MIC_MODE_RGMII
    } mic_mode_t;

    typedef enum logic [1:0] {
        MIC_EB_IDLE,
        MIC_EB_FILL,
        MIC_EB_DRAIN
    } mic_eb_state_t;

    typedef struct packed {
        logic [1:0] sgmii_thr;
        logic rx_dly;
        logic tx_dly;
        logic rsv10;
        logic rgmii;
        logic rsv8;
        logic clk_sel;
        logic rsv6;
        logic rmii;
        logic rmii_rev;
        logic [1:0] eb_size;
    } mic_ctrl_t;

    typedef struct packed {
        logic dv;
        logic [1:0] data;
    } mic_dibit_t;

    typedef struct packed {
        logic rx_dly;
        logic tx_dly;
        logic rgmii;
        logic clk_sel;
        logic rmii;
    } mic_strap_t;

endpackage

// ==== hdl/mic_sync.sv ====
// two flip-flop synchroniser for levels from outside the clock domain
// assumes each bit is an independent level
`timescale 1ns/100ps
module mic_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ==== test/mic_properties.sv ====
// assertions on the ports of the mac interface control block
// assumes a bind onto mic_top and straps held steady through the run
`timescale 1ns/100ps
module mic_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic strap_rx_dly,
    input wire logic strap_tx_dly,
    input wire logic strap_rgmii,
    input wire logic strap_clk_sel,
    input wire logic strap_rmii,
    input wire logic crs_dv,
    input wire logic [1:0] rxd,
    input wire logic [1:0] if_mode,
    input wire logic ref_50m,
    input wire logic rx_clk_dly_en,
    input wire logic tx_clk_dly_en,
    input wire logic [3:0] sgmii_thr_bits,
    input wire logic [2:0] eb_tol_bits
);
    logic [1:0] up_ff;
    // counts the edges since reset release until decoded outputs are valid
    always_ff @(posedge clk) begin
        if (rst) begin
            up_ff <= 2'h0;
        end else if (up_ff != 2'h3) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_hold7(sig);
        ##1 $stable(sig) [*7];
    endsequence
    chk_ready_pulse: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_strap_mode: assert property (
        $fell(rst) |-> ##3 if_mode == (strap_rgmii ? 2'h2 : {1'b0, strap_rmii}))
        else $error("mode not taken from straps");
    chk_strap_clock: assert property ($fell(rst) |-> ##3 ref_50m == strap_clk_sel)
        else $error("clock select not taken from strap");
    chk_strap_delay: assert property (
        $fell(rst) |-> ##3 rx_clk_dly_en == (strap_rx_dly & strap_rgmii)
            && tx_clk_dly_en == (strap_tx_dly & strap_rgmii))
        else $error("delay enables not taken from straps");
    chk_delay_rgmii: assert property (rx_clk_dly_en || tx_clk_dly_en |-> if_mode == 2'h2)
        else $error("delay active outside rgmii");
    chk_thr_codes: assert property (
        up_ff == 2'h3 |-> sgmii_thr_bits inside {4'h2, 4'h5, 4'h6, 4'ha})
        else $error("threshold outside its table");
    chk_tol_codes: assert property (
        up_ff == 2'h3 |-> eb_tol_bits inside {3'h2, 3'h3, 3'h4, 3'h5})
        else $error("tolerance outside its table");
    chk_rxd_tick: assert property ($changed(rxd) |-> s_hold7(rxd))
        else $error("receive dibit off the tick");
    chk_crs_tick: assert property ($changed(crs_dv) |-> s_hold7(crs_dv))
        else $error("carrier valid off the tick");
endmodule

bind mic_top mic_properties i_chk (.clk, .rst, .psel, .penable, .pready, .strap_rx_dly,
    .strap_tx_dly, .strap_rgmii, .strap_clk_sel, .strap_rmii, .crs_dv, .rxd, .if_mode,
    .ref_50m, .rx_clk_dly_en, .tx_clk_dly_en, .sgmii_thr_bits, .eb_tol_bits);

// ==== test/mic_link_model.sv ====
// behavioural source of the recovered receive link feeding the block
// assumes the bench calls send and nothing else drives these pins
`timescale 1ns/100ps
module mic_link_model (
    output logic link_clk,
    output logic link_dv,
    output logic [1:0] link_data
);
    initial begin
        link_clk = 1'b0;
        link_dv = 1'b0;
        link_data = 2'h1;
    end
    // clock runs through the frame and two periods after carrier drops; stall freezes it mid-frame with carrier up
    task automatic send(input int n, input int stall, input int half);
        #37;
        for (int i = 0; i < n + 2; i++) begin
            link_dv = (i < n);
            link_data = (i < n) ? 2'(i + 1) : ~link_data;
            if (i == n / 2) #(stall);
            #(half) link_clk = 1'b1;
            #(half) link_clk = 1'b0;
        end
        link_data = ~link_data;
    endtask
endmodule

// ==== test/mic_top_bench.sv ====
// self-checking bench of the mac interface control block
// assumes apb access on clk and a link model driving the receive pins
`timescale 1ns/100ps
`include "mic_regs.svh"
module mic_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic strap_rx_dly = 1'b1;
    logic strap_tx_dly = 1'b1;
    logic strap_rgmii = 1'b0;
    logic strap_clk_sel = 1'b1;
    logic strap_rmii = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, link_clk, link_dv, crs_dv, ref_50m, irq, crs_q;
    logic rx_clk_dly_en, tx_clk_dly_en;
    logic [1:0] link_data, rxd, if_mode;
    logic [3:0] sgmii_thr_bits;
    logic [2:0] eb_tol_bits;
    logic [3:0] thr [4] = '{4'h5, 4'h2, 4'h6, 4'ha};
    logic [2:0] tol [4] = '{3'h5, 3'h2, 3'h3, 3'h4};
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int falls = 0;
    int rx_sum = 0;

    mic_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .strap_rx_dly, .strap_tx_dly, .strap_rgmii, .strap_clk_sel, .strap_rmii,
        .link_clk, .link_dv, .link_data, .crs_dv, .rxd, .if_mode, .ref_50m, .rx_clk_dly_en,
        .tx_clk_dly_en, .sgmii_thr_bits, .eb_tol_bits, .irq);
    mic_link_model i_mac (.link_clk, .link_dv, .link_data);

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        crs_q <= crs_dv;
        if (crs_q === 1'b1 && crs_dv === 1'b0) falls++;
        rx_sum += rxd;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic frame(input logic [31:0] ctrl, input int stall);
        xfer(1'b1, `MIC_CTRL_ADDR, ctrl);
        falls = 0;
        rx_sum = 0;
        i_mac.send(12, stall, 100);
        repeat (64) @(posedge clk);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(rd, 32'h58e1);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(rd, 32'h58ed);
        check(ref_50m, 1'b1);
        check(if_mode, 2'h1);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, `MIC_CTRL_ADDR, 32'h98e0 | (32'(c) << 13) | 32'(c));
            xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
            check(rd, 32'h18ec | (32'(c) << 13) | 32'(c));
            check(sgmii_thr_bits, thr[c]);
            check(eb_tol_bits, tol[c]);
        end
        xfer(1'b1, `MIC_CTRL_ADDR, 32'h1ae1);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(if_mode, 2'h2);
        check({rx_clk_dly_en, tx_clk_dly_en}, 2'h3);
        xfer(1'b1, `MIC_CTRL_ADDR, 32'h18c1);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(if_mode, 2'h0);
        check({rx_clk_dly_en, tx_clk_dly_en}, 2'h0);
        frame(32'h18e0, 0);
        check(falls > 1, 1'b1);
        check(rx_sum, 144);
        frame(32'h18f0, 0);
        check(falls, 1);
        check(rx_sum, 144);
        xfer(1'b1, `MIC_INT_STAT_ADDR, 32'h3);
        frame(32'h18e1, 1000);
        check(rx_sum, 144);
        check(irq, 1'b0);
        xfer(1'b0, `MIC_INT_STAT_ADDR, 32'h0);
        check(rd, 32'h2);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(rd & 32'hc, 32'h8);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(rd & 32'hc, 32'hc);
        xfer(1'b1, `MIC_INT_MASK_ADDR, 32'h2);
        @(posedge clk);
        check(irq, 1'b1);
        xfer(1'b1, `MIC_INT_STAT_ADDR, 32'h2);
        @(posedge clk);
        check(irq, 1'b0);
        i_mac.send(40, 0, 50);
        repeat (150) @(posedge clk);
        check(irq, 1'b0);
        xfer(1'b0, `MIC_INT_STAT_ADDR, 32'h0);
        check(rd, 32'h1);
        xfer(1'b0, `MIC_CTRL_ADDR, 32'h0);
        check(rd & 32'hc, 32'h4);
        xfer(1'b0, 12'h200, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        conclude();
    end
endmodule
